// >>> hw/fsbu_top.sv
`timescale 1ns/1ps
// Function
// - key disabled: key writes still diverted, but no capture, unlock or reject
// - key access on: key writes captured, no command
// - clearing access with full match unsecures
// - key accepted only from code in RAM
// - secure part refuses debug module enable
// - secure background entry needs pin low strap
// - protect register written only by background debug
// - erased blank check unsecures until reset
// - security field 1:0 means unsecured
// - nonvolatile area loads options, holds key
// - vector block protection also guards key
// - unlock never alters stored protection or key
module fsbu_top (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire fsbu_pkg::fsbu_bus_wr_s bus_wr_in,
   input wire logic protect_wr_in,
   input wire logic cfg_wr_in,
   input wire logic cfg_key_access_in,
   input wire logic [7:0] nonvolatile_option_byte_in,
   input wire logic [7:0] nonvolatile_protect_byte_in,
   input wire logic [63:0] backdoor_key_location_in,
   input wire logic blank_check_done_in,
   input wire logic blank_check_erased_in,
   input wire logic debug_enable_req_in,
   input wire logic background_mode_select_pin_in,
   output logic [1:0] security_field_out,
   output logic secure_out,
   output logic backdoor_key_enable_out,
   output logic key_access_mode_out,
   output logic [7:0] flash_protect_register_out,
   output fsbu_pkg::fsbu_flash_cmd_s flash_cmd_out,
   output logic key_reject_out,
   output logic debug_enable_out,
   output logic background_entry_allow_out,
   output logic ready_out
);

   fsbu_pkg::fsbu_state_e state_reg;
   fsbu_pkg::fsbu_state_e state_next;
   logic [1:0] sec_reg;
   logic [1:0] sec_next;
   logic key_en_reg;
   logic key_en_next;
   logic key_access_reg;
   logic key_access_next;
   logic [7:0] prot_reg;
   logic [7:0] prot_next;
   fsbu_pkg::fsbu_flash_cmd_s cmd_reg;
   fsbu_pkg::fsbu_flash_cmd_s cmd_next;
   logic reject_reg;
   logic reject_next;
   logic debug_reg;
   logic debug_next;
   logic bgnd_reg;
   logic bgnd_next;
   logic secure_reg;
   logic secure_next;
   logic ready_reg;
   logic ready_next;

   logic running;
   logic loading;
   logic access_opening;
   logic key_unlock;
   logic key_refused;
   logic blank_unlock;
   logic prot_bdc_write;
   logic vector_guarded;
   logic cmd_accept;
   logic in_key_range;
   logic in_vector_block;
   logic in_nv_area;
   logic key_write;
   logic key_capture;
   logic key_clear;
   logic access_closing;
   logic key_all_match;
   logic strap_level;
   logic strap_valid;
   logic [fsbu_pkg::KEY_BYTES-1:0] slot_match;
   logic [fsbu_pkg::KEY_BYTES-1:0] slot_written;

   assign running = (state_reg == fsbu_pkg::FSBU_ST_RUN);
   assign loading = (state_reg == fsbu_pkg::FSBU_ST_LOAD);
   assign in_key_range = bus_wr_in.addr >= fsbu_pkg::KEY_FIRST_ADDR &&
      bus_wr_in.addr <= fsbu_pkg::KEY_LAST_ADDR;
   assign in_vector_block = bus_wr_in.addr >= fsbu_pkg::VECTOR_BLOCK_FIRST;
   assign in_nv_area = bus_wr_in.addr >= fsbu_pkg::NV_FIRST_ADDR &&
      bus_wr_in.addr <= fsbu_pkg::NV_LAST_ADDR;

   // any non-protect write to a key location while access is open is diverted
   assign key_write = running && bus_wr_in.wr && !protect_wr_in &&
      key_access_reg && in_key_range;
   // only RAM code with the key enabled may fill the comparison bytes
   assign key_capture = key_write && key_en_reg && bus_wr_in.from_ram &&
      !bus_wr_in.from_bdc;
   assign access_closing = running && cfg_wr_in && key_access_reg &&
      !cfg_key_access_in;
   assign access_opening = running && cfg_wr_in && cfg_key_access_in &&
      !key_access_reg;
   // a fresh attempt always starts from empty slots
   assign key_clear = access_opening || access_closing;
   assign key_all_match = &slot_match && &slot_written;
   // with the key disabled a close gives neither unlock nor reject
   assign key_unlock = access_closing && key_en_reg && key_all_match;
   assign key_refused = access_closing && key_en_reg && !key_all_match;
   // unconditional path, whatever master ran the blank check
   assign blank_unlock = running && blank_check_done_in &&
      blank_check_erased_in;
   // application stores cannot touch block protection
   assign prot_bdc_write = running && protect_wr_in && bus_wr_in.wr &&
      bus_wr_in.from_bdc;
   // key and options share the vector block, so both are guarded
   assign vector_guarded = prot_reg[fsbu_pkg::PROT_VECTOR_BIT] &&
      (in_vector_block || in_nv_area);
   // diverted key bytes and protect writes never reach the flash
   assign cmd_accept = running && bus_wr_in.wr && !protect_wr_in &&
      !key_write && !vector_guarded;

   // slot i compares against byte i of the stored key, lowest address first
   genvar gi;
   generate
      for (gi = 0; gi < fsbu_pkg::KEY_BYTES; gi++) begin : g_slot
         fsbu_key_slot #(
            .SLOT_ADDR(16'(fsbu_pkg::KEY_FIRST_ADDR + 16'(gi)))
         ) u_slot (
            .mclk_in(mclk_in),
            .rst_in(rst_in),
            .ce_in(ce_in),
            .clear_in(key_clear),
            .capture_in(key_capture),
            .addr_in(bus_wr_in.addr),
            .data_in(bus_wr_in.data),
            .stored_in(backdoor_key_location_in[gi*8 +: 8]),
            .match_out(slot_match[gi]),
            .written_out(slot_written[gi])
         );
      end
   endgenerate

   fsbu_strap_sample u_strap (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .pin_in(background_mode_select_pin_in),
      .level_out(strap_level),
      .valid_out(strap_valid)
   );

   // load sequencing: one cycle to copy the nonvolatile bytes
   // ready lives in its own flop so the port has no logic behind it
   always_comb begin
      state_next = state_reg;
      ready_next = ready_reg;
      case (state_reg)
         fsbu_pkg::FSBU_ST_LOAD: begin
            state_next = fsbu_pkg::FSBU_ST_RUN;
            ready_next = 1'b1;
         end
         fsbu_pkg::FSBU_ST_RUN: begin
            ready_next = 1'b1;
         end
         default: begin
            state_next = fsbu_pkg::FSBU_ST_LOAD;
            ready_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= fsbu_pkg::FSBU_ST_LOAD;
         ready_reg <= 1'b0;
      end else if (ce_in) begin
         state_reg <= state_next;
         ready_reg <= ready_next;
      end
   end

   // security field, key enable and key access
   always_comb begin
      sec_next = sec_reg;
      key_en_next = key_en_reg;
      key_access_next = key_access_reg;
      reject_next = 1'b0;
      if (loading) begin
         // working copies of the nonvolatile bytes, taken once
         sec_next = {nonvolatile_option_byte_in[fsbu_pkg::OPT_SEC_HIGH_BIT],
            nonvolatile_option_byte_in[fsbu_pkg::OPT_SEC_LOW_BIT]};
         key_en_next =
            nonvolatile_option_byte_in[fsbu_pkg::OPT_KEY_EN_BIT];
      end else if (running) begin
         if (cfg_wr_in) begin
            key_access_next = cfg_key_access_in;
         end
         if (key_unlock) begin
            // only the working field moves; nonvolatile stays put
            sec_next = fsbu_pkg::SEC_UNSECURED;
         end
         reject_next = key_refused;
         if (blank_unlock) begin
            sec_next = fsbu_pkg::SEC_UNSECURED;
         end
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         sec_reg <= fsbu_pkg::SEC_RESET;
         key_en_reg <= 1'b0;
         key_access_reg <= 1'b0;
         reject_reg <= 1'b0;
      end else if (ce_in) begin
         sec_reg <= sec_next;
         key_en_reg <= key_en_next;
         key_access_reg <= key_access_next;
         reject_reg <= reject_next;
      end
   end

   // block protection: loaded once, then only background debug writes it
   always_comb begin
      prot_next = prot_reg;
      if (loading) begin
         prot_next = nonvolatile_protect_byte_in;
      end else if (prot_bdc_write) begin
         prot_next = bus_wr_in.data;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         prot_reg <= fsbu_pkg::PROT_RESET;
      end else if (ce_in) begin
         prot_reg <= prot_next;
      end
   end

   // flash command forwarding
   always_comb begin
      cmd_next.valid = 1'b0;
      cmd_next.addr = bus_wr_in.addr;
      cmd_next.data = bus_wr_in.data;
      // address and data ride along; only valid decides
      if (cmd_accept) begin
         cmd_next.valid = 1'b1;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         cmd_reg.valid <= 1'b0;
         cmd_reg.addr <= fsbu_pkg::ADDR_RESET;
         cmd_reg.data <= fsbu_pkg::BYTE_RESET;
      end else if (ce_in) begin
         cmd_reg <= cmd_next;
      end
   end

   // debug gating, follows the security field in the same cycle
   always_comb begin
      secure_next = (sec_next != fsbu_pkg::SEC_UNSECURED);
      debug_next = debug_enable_req_in && !secure_next;
      // before the strap is caught, a secure part keeps entry closed
      bgnd_next = !secure_next ||
         (strap_valid && !strap_level);
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         secure_reg <= 1'b1;
         debug_reg <= 1'b0;
         bgnd_reg <= 1'b0;
      end else if (ce_in) begin
         secure_reg <= secure_next;
         debug_reg <= debug_next;
         bgnd_reg <= bgnd_next;
      end
   end

   assign security_field_out = sec_reg;
   assign secure_out = secure_reg;
   assign backdoor_key_enable_out = key_en_reg;
   assign key_access_mode_out = key_access_reg;
   assign flash_protect_register_out = prot_reg;
   assign flash_cmd_out = cmd_reg;
   assign key_reject_out = reject_reg;
   assign debug_enable_out = debug_reg;
   assign background_entry_allow_out = bgnd_reg;
   assign ready_out = ready_reg;

endmodule // fsbu_top

// >>> hw/fsbu_pkg.sv
package fsbu_pkg;

   // nonvolatile register area and its layout
   localparam logic [15:0] NV_FIRST_ADDR = 16'hffb0;
   localparam logic [15:0] NV_LAST_ADDR = 16'hffbf;
   localparam logic [15:0] KEY_FIRST_ADDR = 16'hffb0;
   localparam logic [15:0] KEY_LAST_ADDR = 16'hffb7;
   localparam int KEY_BYTES = 8;

   // 512-byte block holding the vectors and the nonvolatile area
   localparam logic [15:0] VECTOR_BLOCK_FIRST = 16'hfe00;

   // option byte fields
   localparam int OPT_KEY_EN_BIT = 7;
   localparam int OPT_SEC_HIGH_BIT = 1;
   localparam int OPT_SEC_LOW_BIT = 0;

   // protect byte field: vector block write-protected while set
   localparam int PROT_VECTOR_BIT = 0;

   // security field encodings and reset values
   localparam logic [1:0] SEC_UNSECURED = 2'h2;
   localparam logic [1:0] SEC_RESET = 2'h3;
   localparam logic [7:0] PROT_RESET = 8'h01;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [15:0] ADDR_RESET = 16'h0000;

   typedef enum logic [0:0] {
      FSBU_ST_LOAD = 1'b0,
      FSBU_ST_RUN = 1'b1
   } fsbu_state_e;

   // one byte write from a bus master
   typedef struct packed {
      logic wr;
      logic [15:0] addr;
      logic [7:0] data;
      logic from_ram;
      logic from_bdc;
   } fsbu_bus_wr_s;

   // flash program or erase step handed to the flash controller
   typedef struct packed {
      logic valid;
      logic [15:0] addr;
      logic [7:0] data;
   } fsbu_flash_cmd_s;

endpackage

// >>> hw/fsbu_key_slot.sv
`timescale 1ns/1ps
// one captured backdoor key byte and its comparison
module fsbu_key_slot #(
   parameter logic [15:0] SLOT_ADDR = 16'hffb0
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic clear_in,
   input wire logic capture_in,
   input wire logic [15:0] addr_in,
   input wire logic [7:0] data_in,
   input wire logic [7:0] stored_in,
   output logic match_out,
   output logic written_out
);

   logic [7:0] byte_reg;
   logic [7:0] byte_next;
   logic written_reg;
   logic written_next;

   always_comb begin
      byte_next = byte_reg;
      written_next = written_reg;
      if (clear_in) begin
         byte_next = fsbu_pkg::BYTE_RESET;
         written_next = 1'b0;
      end else if (capture_in && addr_in == SLOT_ADDR) begin
         byte_next = data_in;
         written_next = 1'b1;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         byte_reg <= fsbu_pkg::BYTE_RESET;
         written_reg <= 1'b0;
      end else if (ce_in) begin
         byte_reg <= byte_next;
         written_reg <= written_next;
      end
   end

   assign match_out = written_reg && (byte_reg == stored_in);
   assign written_out = written_reg;

endmodule // fsbu_key_slot

// >>> hw/fsbu_strap_sample.sv
`timescale 1ns/1ps
// catches a pin level at the first enabled edge after reset release
module fsbu_strap_sample (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic pin_in,
   output logic level_out,
   output logic valid_out
);

   logic level_reg;
   logic level_next;
   logic valid_reg;
   logic valid_next;

   always_comb begin
      level_next = level_reg;
      valid_next = valid_reg;
      if (!valid_reg) begin
         level_next = pin_in;
         valid_next = 1'b1;
      end
   end

   // async reset loads a constant; the pin is only sampled by the clock
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         level_reg <= 1'b1;
         valid_reg <= 1'b0;
      end else if (ce_in) begin
         level_reg <= level_next;
         valid_reg <= valid_next;
      end
   end

   assign level_out = level_reg;
   assign valid_out = valid_reg;

endmodule // fsbu_strap_sample

// >>> verification/fsbu_chk_assertions.sv
`timescale 1ns/1ps
module fsbu_chk (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire fsbu_pkg::fsbu_bus_wr_s bus_wr_in,
   input wire logic protect_wr_in,
   input wire logic cfg_wr_in,
   input wire logic cfg_key_access_in,
   input wire logic blank_check_done_in,
   input wire logic blank_check_erased_in,
   input wire logic debug_enable_req_in,
   input wire logic [1:0] security_field_out,
   input wire logic secure_out,
   input wire logic backdoor_key_enable_out,
   input wire logic key_access_mode_out,
   input wire logic [7:0] flash_protect_register_out,
   input wire fsbu_pkg::fsbu_flash_cmd_s flash_cmd_out,
   input wire logic key_reject_out,
   input wire logic debug_enable_out,
   input wire logic ready_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   logic take;
   logic close;
   assign take = ce_in && ready_out && bus_wr_in.wr;
   assign close = cfg_wr_in && !cfg_key_access_in && key_access_mode_out;
   a_field_sec_agree: assert property (
      secure_out == (security_field_out != 2'h2))
      else $error("secure flag disagrees with field");
   a_key_no_cmd: assert property (take && key_access_mode_out &&
      bus_wr_in.addr inside {[16'hffb0:16'hffb7]} |=> !flash_cmd_out.valid)
      else $error("key write became a flash command");
   a_vector_guard: assert property (take && !protect_wr_in &&
      flash_protect_register_out[0] && bus_wr_in.addr >= 16'hfe00
      |=> !flash_cmd_out.valid)
      else $error("protected block accepted a command");
   a_cmd_origin: assert property (flash_cmd_out.valid |-> $past(take) &&
      !$past(protect_wr_in) && flash_cmd_out.addr == $past(bus_wr_in.addr)
      && flash_cmd_out.data == $past(bus_wr_in.data))
      else $error("command without matching write");
   a_app_prot_held: assert property (
      take && protect_wr_in && !bus_wr_in.from_bdc
      |=> $stable(flash_protect_register_out))
      else $error("application changed protection");
   a_unlock_cause: assert property (
      $fell(secure_out) && $past(ready_out) |->
      ($past(blank_check_done_in) && $past(blank_check_erased_in)) ||
      ($past(close) && $past(backdoor_key_enable_out)))
      else $error("security lifted without cause");
   a_reject_cause: assert property (key_reject_out |->
      $past(close) && $past(backdoor_key_enable_out))
      else $error("reject without enabled key close");
   a_reject_hold: assert property (
      key_reject_out |-> $stable(security_field_out))
      else $error("mismatch changed security");
   a_debug_gate: assert property (debug_enable_out |->
      $past(debug_enable_req_in) && !secure_out)
      else $error("debug enabled while secure");
   a_debug_follow: assert property (
      $past(ce_in) && $past(debug_enable_req_in) && !secure_out
      |-> debug_enable_out)
      else $error("debug request ignored while open");
endmodule // fsbu_chk

bind fsbu_top fsbu_chk chk (.mclk_in, .rst_in, .ce_in, .bus_wr_in,
   .protect_wr_in, .cfg_wr_in, .cfg_key_access_in, .blank_check_done_in,
   .blank_check_erased_in, .debug_enable_req_in, .security_field_out,
   .secure_out, .backdoor_key_enable_out, .key_access_mode_out,
   .flash_protect_register_out, .flash_cmd_out, .key_reject_out,
   .debug_enable_out, .ready_out);

// >>> verification/fsbu_host_model.sv
`timescale 1ns/1ps
module fsbu_host_model (
   input wire logic mclk_in,
   output fsbu_pkg::fsbu_bus_wr_s bus_out,
   output logic prot_out
);
   initial begin
      bus_out = '0;
      prot_out = 1'b0;
   end
   // idle bus shows inverted stale values, never the last write
   task automatic wr(input logic [15:0] a, input logic [7:0] d,
      input logic ram, input logic bdc, input logic prot);
      @(negedge mclk_in);
      bus_out = '{1'b1, a, d, ram, bdc};
      prot_out = prot;
      @(negedge mclk_in);
      bus_out = '{1'b0, ~a, ~d, 1'b0, 1'b0};
      prot_out = 1'b0;
   endtask
   // one idle cycle always separates two key bytes
   task automatic key_seq(input logic [63:0] k, input logic ram,
      input logic bdc);
      for (int i = 0; i < fsbu_pkg::KEY_BYTES; i++) begin
         wr(16'hffb0 + 16'(i), k[8*i +: 8], ram, bdc, 1'b0);
      end
   endtask
endmodule // fsbu_host_model

// >>> verification/tb_flash_security_backdoor_unlock.sv
`timescale 1ns/1ps
module tb_flash_security_backdoor_unlock;
   localparam logic [63:0] KEY = 64'h0123456789abcdef;
   logic mclk_in = 1'b0;
   logic rst_in, ce_in, protect_wr_in, cfg_wr_in, cfg_key_access_in;
   logic blank_check_done_in, blank_check_erased_in, debug_enable_req_in;
   logic background_mode_select_pin_in;
   logic [7:0] nonvolatile_option_byte_in, nonvolatile_protect_byte_in;
   logic [63:0] backdoor_key_location_in = KEY;
   fsbu_pkg::fsbu_bus_wr_s bus_wr_in;
   fsbu_pkg::fsbu_flash_cmd_s flash_cmd_out;
   logic [1:0] security_field_out;
   logic [7:0] flash_protect_register_out;
   logic secure_out, backdoor_key_enable_out, key_access_mode_out;
   logic key_reject_out, debug_enable_out, background_entry_allow_out;
   logic ready_out;
   int n_errors = 0;
   int n_compared = 0;

   always #2 mclk_in = ~mclk_in;

   fsbu_host_model m (.mclk_in, .bus_out(bus_wr_in), .prot_out(protect_wr_in));
   fsbu_top uut (.mclk_in, .rst_in, .ce_in, .bus_wr_in, .protect_wr_in,
      .cfg_wr_in, .cfg_key_access_in, .nonvolatile_option_byte_in,
      .nonvolatile_protect_byte_in, .backdoor_key_location_in,
      .blank_check_done_in, .blank_check_erased_in, .debug_enable_req_in,
      .background_mode_select_pin_in, .security_field_out, .secure_out,
      .backdoor_key_enable_out, .key_access_mode_out,
      .flash_protect_register_out, .flash_cmd_out, .key_reject_out,
      .debug_enable_out, .background_entry_allow_out, .ready_out);

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic close_out;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ends one negedge after the load edge, so ready is already up
   task automatic do_reset(input logic [7:0] o, input logic [7:0] p,
      input logic pin);
      @(negedge mclk_in);
      rst_in = 1'b1;
      nonvolatile_option_byte_in = o;
      nonvolatile_protect_byte_in = p;
      background_mode_select_pin_in = pin;
      repeat (12) @(negedge mclk_in);
      rst_in = 1'b0;
      @(negedge mclk_in);
      chk(ready_out, 1'b1);
   endtask

   task automatic cfg(input logic v);
      @(negedge mclk_in);
      cfg_wr_in = 1'b1;
      cfg_key_access_in = v;
      @(negedge mclk_in);
      cfg_wr_in = 1'b0;
   endtask

   task automatic dbg_try(input logic exp);
      debug_enable_req_in = 1'b1;
      @(negedge mclk_in);
      chk(debug_enable_out, exp);
      debug_enable_req_in = 1'b0;
   endtask

   task automatic s_load_cmd;
      do_reset(8'h03, 8'h01, 1'b1);
      chk({security_field_out, flash_protect_register_out}, 10'h301);
      chk(background_entry_allow_out, 1'b0);
      m.wr(16'h1000, 8'h55, 1'b0, 1'b0, 1'b0);
      chk(flash_cmd_out, {1'b1, 16'h1000, 8'h55});
      m.wr(16'hfe10, 8'haa, 1'b0, 1'b0, 1'b0);
      chk(flash_cmd_out.valid, 1'b0);
      dbg_try(1'b0);
      // a write under a low clock enable must leave no trace
      ce_in = 1'b0;
      m.wr(16'h1000, 8'h66, 1'b0, 1'b0, 1'b0);
      chk(flash_cmd_out.valid, 1'b0);
      ce_in = 1'b1;
   endtask

   task automatic s_prot;
      m.wr(16'h0000, 8'h00, 1'b0, 1'b0, 1'b1);
      chk(flash_protect_register_out, 8'h01);
      m.wr(16'h0000, 8'h00, 1'b0, 1'b1, 1'b1);
      chk(flash_protect_register_out, 8'h00);
      m.wr(16'hfe10, 8'haa, 1'b0, 1'b0, 1'b0);
      chk(flash_cmd_out.valid, 1'b1);
   endtask

   task automatic s_key(input logic [7:0] o, input logic [63:0] k,
      input logic ram, input logic bdc, input logic [1:0] f, input logic r);
      do_reset(o, 8'h01, 1'b1);
      cfg(1'b1);
      chk(key_access_mode_out, 1'b1);
      m.key_seq(k, ram, bdc);
      chk(flash_cmd_out.valid, 1'b0);
      cfg(1'b0);
      chk(key_reject_out, r);
      chk(security_field_out, f);
      chk(flash_protect_register_out, 8'h01);
      dbg_try(f == 2'h2);
   endtask

   task automatic s_blank;
      do_reset(8'h03, 8'h01, 1'b0);
      // the strap is caught on the load edge, entry opens one edge later
      @(negedge mclk_in);
      chk(background_entry_allow_out, 1'b1);
      @(negedge mclk_in);
      blank_check_done_in = 1'b1;
      blank_check_erased_in = 1'b1;
      @(negedge mclk_in);
      blank_check_done_in = 1'b0;
      chk({security_field_out, secure_out}, 3'b100);
   endtask

   task automatic s_nv_open;
      do_reset(8'h82, 8'h00, 1'b1);
      chk({secure_out, backdoor_key_enable_out}, 2'b01);
   endtask

   initial begin
      rst_in = 1'b1;
      ce_in = 1'b1;
      cfg_wr_in = 1'b0;
      cfg_key_access_in = 1'b0;
      blank_check_done_in = 1'b0;
      blank_check_erased_in = 1'b0;
      debug_enable_req_in = 1'b0;
      background_mode_select_pin_in = 1'b1;
      nonvolatile_option_byte_in = 8'h03;
      nonvolatile_protect_byte_in = 8'h01;
      s_load_cmd;
      s_prot;
      s_key(8'h83, KEY, 1'b1, 1'b0, 2'h2, 1'b0);
      s_key(8'h83, KEY ^ 64'h100, 1'b1, 1'b0, 2'h3, 1'b1);
      s_key(8'h83, KEY, 1'b1, 1'b1, 2'h3, 1'b1);
      s_key(8'h83, KEY, 1'b0, 1'b0, 2'h3, 1'b1);
      s_key(8'h03, KEY, 1'b1, 1'b0, 2'h3, 1'b0);
      s_blank;
      s_nv_open;
      close_out;
   end

   // run needs well under 1000 cycles
   initial begin
      #20000;
      n_errors++;
      close_out;
   end
endmodule // tb_flash_security_backdoor_unlock
